//--- hw/compute_group_walker_decoder.sv
// Functional notes
// RULE1: Indirect pointer offset, 64-byte aligned, top bits zero.
// RULE2: Zero indirect length means pointer ignored.
// RULE3: Single command gives full X, Y, Z coordinates.
// RULE4: Mask bit n enables channel n.
// RULE5: Narrow dispatches use low mask bits.
// RULE6: Masked-off channels make no memory access.
// RULE7: Software flushes memory before dependent walks.
// RULE8: Header bit 10 selects dimension registers.
// RULE9: Predicate enabled and state zero skips command.
// RULE10: Length field is count minus two, 9.
// RULE11: Descriptor offset is six-bit unit index.
// RULE12: Width code picks 8, 16, 32 mask bits.
// RULE13: Kernel width must match declared width.
// RULE14: Thread maxima from dword 2 fields.
// RULE15: Thread maxima product bounded by width.
// RULE16: X starts at start, wraps to zero.
// RULE17: Y starts at start, wraps to zero.
// RULE18: Z starts at starting Z dword.
// RULE19: Dimension dwords are counts, max is minus one.
// RULE20: Walk opcode 3/2/1/5, reserved bits zero.
// RULE21: Edge masks at last X and Y.
// RULE22: X fastest, then Y, then Z.
`timescale 1ns/100ps
module compute_group_walker_decoder
  import group_walk_pkg::*;
(
  // Clock and reset.
  input  wire logic         MCLK,
  input  wire logic         NRST,
  // Command dword stream from the parser.
  input  wire logic         CMD_VALID,
  input  wire logic [31:0]  CMD_DATA,
  output logic              CMD_READY,
  // Pipeline state.
  input  wire logic         PREDICATE_STATE,
  input  wire logic [31:0]  DIM_X,
  input  wire logic [31:0]  DIM_Y,
  input  wire logic [31:0]  DIM_Z,
  // Thread dispatch output.
  output dispatch_type      DISPATCH,
  output logic              DISPATCH_VALID,
  input  wire logic         DISPATCH_READY,
  // Status.
  output logic              CMD_ERROR,
  output logic              BUSY
);

  ////////////////////////////////////////////////////////////////////////////
  walk_state_type     state_reg, state_next;
  logic [31:0]        dw_reg [0:10];
  logic [31:0]        dw_next [0:10];
  logic [3:0]         idx_reg, idx_next;
  logic [3:0]         last_reg, last_next;
  logic               walk_reg, walk_next;
  logic               skip_reg, skip_next;
  logic [31:0]        x_reg, x_next, y_reg, y_next, z_reg, z_next;
  logic [31:0]        dimx_reg, dimx_next, dimy_reg, dimy_next, dimz_reg, dimz_next;
  dispatch_type       disp_reg, disp_next;
  logic               dval_reg, dval_next;
  logic               err_reg, err_next;
  logic               hdr_ok, ptr_ok;
  logic [31:0]        width_mask, edge_mask;
  logic               at_last_x, at_last_y, at_last_z;

  // Header decode, live mask bits, walk edges and pointer alignment.
  // Counts of zero are treated as a single group so the walk always ends.
  always_comb begin
    hdr_ok = CMD_DATA[31:HDR_TYPE_LSB] == CMD_TYPE_GFX                   // RULE20
          && CMD_DATA[HDR_TYPE_LSB-1:HDR_PIPE_LSB] == CMD_PIPE_MEDIA
          && CMD_DATA[HDR_PIPE_LSB-1:HDR_OPC_LSB] == CMD_OPCODE;
    case (dw_reg[2][31:SIMD_LSB])                                         // RULE12
      SIMD8_CODE:  width_mask = MASK8;
      SIMD16_CODE: width_mask = MASK16;
      default:     width_mask = MASK32;
    endcase
    at_last_x = (x_reg + 32'h1 >= dimx_reg);                              // RULE19
    at_last_y = (y_reg + 32'h1 >= dimy_reg);
    at_last_z = (z_reg + 32'h1 >= dimz_reg);
    edge_mask = width_mask & (at_last_x ? dw_reg[9] : MASK32)             // RULE21
                           & (at_last_y ? dw_reg[10] : MASK32);
    ptr_ok = (dw_reg[3] & PTR_ALIGN_MASK) == 32'h0;                       // RULE1
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer and walker next state.
  always_comb begin
    state_next = state_reg;
    for (int i = 0; i < 11; i++) begin
      dw_next[i] = dw_reg[i];
    end
    idx_next  = idx_reg;
    last_next = last_reg;
    walk_next = walk_reg;
    skip_next = skip_reg;
    x_next = x_reg;
    y_next = y_reg;
    z_next = z_reg;
    dimx_next = dimx_reg;
    dimy_next = dimy_reg;
    dimz_next = dimz_reg;
    disp_next = disp_reg;
    dval_next = dval_reg && !DISPATCH_READY;
    err_next  = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (CMD_VALID && CMD_READY) begin                                 // Ready is low just after reset.
          dw_next[0] = CMD_DATA;
          idx_next   = 4'h1;
          skip_next  = CMD_DATA[HDR_PRED] && !PREDICATE_STATE;            // RULE9
          if (hdr_ok && CMD_DATA[23:16] == SUBOP_WALK
              && CMD_DATA[7:0] == WALK_LENGTH_VALUE                        // RULE10
              && CMD_DATA[15:11] == 5'h0 && !CMD_DATA[9]) begin           // RULE20
            walk_next  = 1'b1;
            last_next  = 4'ha;
            state_next = ST_FETCH;
          end else if (hdr_ok && CMD_DATA[23:16] == SUBOP_SINGLE
              && CMD_DATA[7:0] == SINGLE_LENGTH_VALUE) begin              // RULE10
            walk_next  = 1'b0;
            last_next  = 4'h7;
            state_next = ST_FETCH;
          end else begin
            err_next = 1'b1;
          end
        end
      end
      ST_FETCH: begin
        if (CMD_VALID && CMD_READY) begin
          dw_next[idx_reg] = CMD_DATA;
          idx_next = idx_reg + 4'h1;
          if (idx_reg == last_reg) begin
            state_next = skip_reg ? ST_IDLE : ST_WALK;                    // RULE9
          end
        end
      end
      ST_WALK: begin
        // Load the walk origin and the group counts, or the single group's coordinates.
        if (walk_reg) begin
          x_next = dw_reg[3];                                             // RULE16
          y_next = dw_reg[5];                                             // RULE17
          z_next = dw_reg[7];                                             // RULE18
          dimx_next = dw_reg[0][HDR_INDIRECT] ? DIM_X : dw_reg[4];        // RULE8
          dimy_next = dw_reg[0][HDR_INDIRECT] ? DIM_Y : dw_reg[6];
          dimz_next = dw_reg[0][HDR_INDIRECT] ? DIM_Z : dw_reg[8];
        end else begin
          x_next = dw_reg[4];                                             // RULE3
          y_next = dw_reg[5];
          z_next = dw_reg[6];
        end
        state_next = ST_DRAIN;
      end
      ST_DRAIN: begin
        if (!dval_reg || DISPATCH_READY) begin
          dval_next = 1'b1;
          disp_next.group_x = x_reg;
          disp_next.group_y = y_reg;
          disp_next.group_z = z_reg;
          disp_next.desc_offset = dw_reg[1][5:0];                         // RULE11
          if (walk_reg) begin
            disp_next.chan_mask = edge_mask;                              // RULE6
            disp_next.simd = dw_reg[2][31:SIMD_LSB];                      // RULE12
            disp_next.thread_max = {dw_reg[2][DEPTH_LSB+5:DEPTH_LSB],     // RULE14
                                    dw_reg[2][HEIGHT_LSB+5:HEIGHT_LSB],
                                    dw_reg[2][WIDTH_LSB+5:WIDTH_LSB]};
            disp_next.indirect_ptr = 32'h0;
            disp_next.indirect_valid = 1'b0;
            // Step X fastest, wrapping X and Y to zero, not to their start; Z only counts up to the end.
            if (!at_last_x) begin                                         // RULE22
              x_next = x_reg + 32'h1;
            end else begin
              x_next = 32'h0;                                             // RULE16
              if (!at_last_y) begin
                y_next = y_reg + 32'h1;
              end else begin
                y_next = 32'h0;                                           // RULE17
                z_next = z_reg + 32'h1;
                if (at_last_z) begin
                  state_next = ST_IDLE;
                end
              end
            end
          end else begin
            disp_next.chan_mask = dw_reg[7];                              // RULE4
            disp_next.simd = SIMD32_CODE;
            disp_next.thread_max = 18'h0;
            // A zero indirect length disables the pointer entirely.
            disp_next.indirect_valid = (dw_reg[2][16:0] != 17'h0);        // RULE2
            disp_next.indirect_ptr = disp_next.indirect_valid ? dw_reg[3] : 32'h0;
            err_next = disp_next.indirect_valid && !ptr_ok;               // RULE1
            state_next = ST_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      state_reg <= ST_IDLE;
      for (int i = 0; i < 11; i++) begin
        dw_reg[i] <= 32'h0;
      end
      idx_reg  <= 4'h0;
      last_reg <= 4'h0;
      walk_reg <= 1'b0;
      skip_reg <= 1'b0;
      x_reg <= 32'h0;
      y_reg <= 32'h0;
      z_reg <= 32'h0;
      dimx_reg <= 32'h0;
      dimy_reg <= 32'h0;
      dimz_reg <= 32'h0;
      disp_reg <= '0;
      dval_reg <= 1'b0;
      err_reg  <= 1'b0;
      CMD_READY <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      state_reg <= state_next;
      for (int i = 0; i < 11; i++) begin
        dw_reg[i] <= dw_next[i];
      end
      idx_reg  <= idx_next;
      last_reg <= last_next;
      walk_reg <= walk_next;
      skip_reg <= skip_next;
      x_reg <= x_next;
      y_reg <= y_next;
      z_reg <= z_next;
      dimx_reg <= dimx_next;
      dimy_reg <= dimy_next;
      dimz_reg <= dimz_next;
      disp_reg <= disp_next;
      dval_reg <= dval_next;
      err_reg  <= err_next;
      // Ready is registered, so it only opens in the idle and fetch states.
      CMD_READY <= (state_next == ST_IDLE) || (state_next == ST_FETCH);
      BUSY <= (state_next != ST_IDLE) || dval_next;
    end
  end

  assign DISPATCH       = disp_reg;
  assign DISPATCH_VALID = dval_reg;
  assign CMD_ERROR      = err_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Every check runs on the one clock and sleeps while reset is low.
  default clocking cb_main @(posedge MCLK);
  endclocking
  default disable iff (!NRST);
  property p_skip;
    (state_reg == ST_FETCH && skip_reg && idx_reg == last_reg && CMD_VALID && CMD_READY)
      |=> state_reg == ST_IDLE && dval_reg == $past(dval_reg && !DISPATCH_READY);
  endproperty
  a_skip: assert property (p_skip) else $error("Predicated command ran."); // RULE9
  property p_xwrap;
    (state_reg == ST_DRAIN && walk_reg && (!dval_reg || DISPATCH_READY) && at_last_x)
      |=> x_reg == 32'h0;
  endproperty
  a_xwrap: assert property (p_xwrap) else $error("X did not wrap to zero."); // RULE16
  property p_ystep;
    (state_reg == ST_DRAIN && walk_reg && (!dval_reg || DISPATCH_READY) && at_last_x
     && !at_last_y) |=> y_reg == $past(y_reg) + 32'h1;
  endproperty
  a_ystep: assert property (p_ystep) else $error("Y did not step after X."); // RULE22
  property p_width;
    (dval_reg && disp_reg.simd == SIMD8_CODE) |-> disp_reg.chan_mask[31:8] == 24'h0;
  endproperty
  a_width: assert property (p_width) else $error("Mask wider than width."); // RULE12
  property p_indirect;
    (dval_reg && !disp_reg.indirect_valid) |-> disp_reg.indirect_ptr == 32'h0;
  endproperty
  a_indirect: assert property (p_indirect) else $error("Pointer leaked."); // RULE2
  property p_start;
    (state_reg == ST_WALK && walk_reg) |=> x_reg == $past(dw_reg[3])
      && z_reg == $past(dw_reg[7]);
  endproperty
  a_start: assert property (p_start) else $error("Walk origin wrong."); // RULE18
  property p_dimreg;
    (state_reg == ST_WALK && walk_reg && dw_reg[0][HDR_INDIRECT])
      |=> dimx_reg == $past(DIM_X);
  endproperty
  a_dimreg: assert property (p_dimreg) else $error("Dimension register unused."); // RULE8
  property p_badlen;
    (state_reg == ST_IDLE && CMD_VALID && CMD_READY && CMD_DATA[23:16] == SUBOP_WALK
     && CMD_DATA[7:0] != WALK_LENGTH_VALUE) |=> CMD_ERROR ##1 !CMD_ERROR;
  endproperty
  a_badlen: assert property (p_badlen) else $error("Bad length accepted."); // RULE10
  c_walk_done: cover property (state_reg == ST_DRAIN && walk_reg ##1 state_reg == ST_IDLE);
  c_single: cover property (dval_reg && disp_reg.indirect_valid);
  c_stall: cover property ((dval_reg && !DISPATCH_READY) [*2]);

endmodule : compute_group_walker_decoder

//--- hw/group_walk_pkg.sv
package group_walk_pkg;

  // Header opcode fields of the walk and single-group commands.
  localparam logic [2:0] CMD_TYPE_GFX        = 3'h3;
  localparam logic [1:0] CMD_PIPE_MEDIA      = 2'h2;
  localparam logic [2:0] CMD_OPCODE          = 3'h1;
  localparam logic [7:0] SUBOP_WALK          = 8'h05;
  localparam logic [7:0] SUBOP_SINGLE        = 8'h04;
  localparam logic [7:0] WALK_LENGTH_VALUE   = 8'h09;
  localparam logic [7:0] SINGLE_LENGTH_VALUE = 8'h06;

  // Header field positions.
  localparam int HDR_TYPE_LSB   = 29;
  localparam int HDR_PIPE_LSB   = 27;
  localparam int HDR_OPC_LSB    = 24;
  localparam int HDR_SUBOP_LSB  = 16;
  localparam int HDR_INDIRECT   = 10;
  localparam int HDR_PRED       = 8;

  // Dword 2 field positions of the walk command.
  localparam int SIMD_LSB       = 30;
  localparam int DEPTH_LSB      = 16;
  localparam int HEIGHT_LSB     = 8;
  localparam int WIDTH_LSB      = 0;

  // Indirect pointer alignment: low 6 bits (64 bytes) and top bits 31:29 zero.
  localparam logic [31:0] PTR_ALIGN_MASK = 32'he000_003f;

  // Width field codes and the matching channel masks.
  localparam logic [1:0]  SIMD8_CODE  = 2'h0;
  localparam logic [1:0]  SIMD16_CODE = 2'h1;
  localparam logic [1:0]  SIMD32_CODE = 2'h2;
  localparam logic [31:0] MASK8       = 32'h0000_00ff;
  localparam logic [31:0] MASK16      = 32'h0000_ffff;
  localparam logic [31:0] MASK32      = 32'hffff_ffff;

  // Thread dispatch record handed to the execution side.
  typedef struct packed {
    logic [31:0] group_x;
    logic [31:0] group_y;
    logic [31:0] group_z;
    logic [31:0] chan_mask;
    logic [1:0]  simd;
    logic [5:0]  desc_offset;
    logic [17:0] thread_max;
    logic [31:0] indirect_ptr;
    logic        indirect_valid;
  } dispatch_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_WALK  = 3'b010,
    ST_DRAIN = 3'b011,
    ST_ERR   = 3'b100
  } walk_state_type;

endpackage : group_walk_pkg

//--- testbench/compute_group_walker_decoder_tb_top.sv
`timescale 1ns/100ps
module compute_group_walker_decoder_tb_top;
  import group_walk_pkg::*;
  logic         mclk, cmd_ready, disp_valid, disp_ready, cmd_error, busy;
  logic         nrst = 0, cmd_valid = 0, pred_state = 0, stall_en = 0;
  logic  [31:0] cmd_data = 0, dim_x = 1, dim_y = 1, dim_z = 1, wmask;
  logic  [31:0] dw [0:10];
  logic  [31:0] bad [0:2];
  dispatch_type disp, e, e2;
  dispatch_type exp_q[$];
  int           kind_q[$];
  int           errors = 0, total_checks = 0, err_seen = 0, err_exp = 0, cycles = 0;
  int           seed = 62519, f, dx, dy, dz, sx, sy, sz, x, y, z;

  compute_group_walker_decoder dut (.MCLK(mclk), .NRST(nrst), .CMD_VALID(cmd_valid),
    .CMD_DATA(cmd_data), .CMD_READY(cmd_ready), .PREDICATE_STATE(pred_state), .DIM_X(dim_x),
    .DIM_Y(dim_y), .DIM_Z(dim_z), .DISPATCH(disp), .DISPATCH_VALID(disp_valid),
    .DISPATCH_READY(disp_ready), .CMD_ERROR(cmd_error), .BUSY(busy));
  dispatch_sink sink (.MCLK(mclk), .NRST(nrst), .stall_en(stall_en), .ready(disp_ready));

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running clock at 25 MHz.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task finish_test;
    $display("Checks made %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // Hold each dword until the edge that accepts it; valid drops only after the last one.
  task send_cmd(input int n);
    for (int i = 0; i < n; i++) begin
      cmd_valid = 1'b1;
      cmd_data  = dw[i];
      do @(posedge mclk); while (cmd_ready !== 1'b1);
      @(negedge mclk);
    end
    // Valid rests low for a full cycle, so a following call never re-raises it in this step.
    cmd_valid = 1'b0;
    @(negedge mclk);
  endtask : send_cmd

  // Waits a bounded time for the walker to drain, then checks counts of groups and errors.
  task settle(input string name);
    repeat (3) @(negedge mclk);
    for (int k = 0; k < 3000 && (busy !== 1'b0 || exp_q.size() != 0); k++) @(negedge mclk);
    check("pending_groups", exp_q.size(), 0);
    check("error_pulses", err_seen, err_exp);
    check("idle_busy_ready", {busy, cmd_ready}, 2'b01);
    $display("Test %s done", name);
  endtask : settle

  // Builds a walk command within the software limits and queues the groups it must give.
  task walk(input logic [1:0] simd, input logic ind, input logic pred, input logic run);
    dx = 1 + ($random(seed) & 3);
    dy = 1 + ($random(seed) & 3);
    dz = 1 + ($random(seed) & 1);
    sx = ($random(seed) & 7) % dx;
    sy = ($random(seed) & 7) % dy;
    sz = ($random(seed) & 7) % dz;
    {dim_x, dim_y, dim_z} = {32'(dx), 32'(dy), 32'(dz)};
    // With bit 10 clear the dimension inputs carry decoys that must be ignored.
    if (!ind) {dim_x, dim_y, dim_z} = {dim_x + 32'h2, dim_y + 32'h2, dim_z + 32'h2};
    pred_state = run;
    dw[0] = {CMD_TYPE_GFX, CMD_PIPE_MEDIA, CMD_OPCODE, SUBOP_WALK, 5'h00, ind, 1'b0, pred,
             WALK_LENGTH_VALUE};
    dw[1] = $random(seed) & 32'h3f;
    // Thread maxima product stays at or below 32 for every width, and the kernel matches it.
    dw[2] = {simd, 8'h00, 6'(1 + ($random(seed) & 3)), 2'h0, 6'(1 + ($random(seed) & 1)),
             2'h0, 6'(1 + ($random(seed) & 3))};
    {dw[3], dw[5], dw[7]} = {32'(sx), 32'(sy), 32'(sz)};
    dw[4] = ind ? dx + 2 : dx;
    dw[6] = ind ? dy + 2 : dy;
    dw[8] = ind ? dz + 2 : dz;
    dw[9] = $random(seed);
    dw[10] = $random(seed);
    wmask = (simd == SIMD8_CODE) ? MASK8 : (simd == SIMD16_CODE) ? MASK16 : MASK32;
    e2 = '0;
    e2.simd = simd;
    e2.desc_offset = dw[1][5:0];
    e2.thread_max = {dw[2][21:16], dw[2][13:8], dw[2][5:0]};
    if (!pred || run) begin
      for (z = sz; z < dz; z++) begin
        for (y = (z == sz) ? sy : 0; y < dy; y++) begin
          for (x = (z == sz && y == sy) ? sx : 0; x < dx; x++) begin
            {e2.group_x, e2.group_y, e2.group_z} = {32'(x), 32'(y), 32'(z)};
            e2.chan_mask = wmask & ((x == dx - 1) ? dw[9] : MASK32)
                                 & ((y == dy - 1) ? dw[10] : MASK32);
            exp_q.push_back(e2);
            kind_q.push_back(0);
          end
        end
      end
    end
    send_cmd(11);
  endtask : walk

  // Single-group command; an indirect length of zero makes the pointer of no account.
  task single(input logic [16:0] len, input logic [31:0] ptr);
    dw[0] = {CMD_TYPE_GFX, CMD_PIPE_MEDIA, CMD_OPCODE, SUBOP_SINGLE, 8'h00, SINGLE_LENGTH_VALUE};
    dw[1] = $random(seed) & 32'h3f;
    dw[2] = {15'h0000, len};
    dw[3] = ptr;
    for (int i = 4; i < 8; i++) dw[i] = $random(seed);
    e2 = '0;
    {e2.group_x, e2.group_y, e2.group_z, e2.chan_mask} = {dw[4], dw[5], dw[6], dw[7]};
    e2.simd = SIMD32_CODE;
    e2.desc_offset = dw[1][5:0];
    e2.indirect_ptr = ptr;
    e2.indirect_valid = (len != 0);
    exp_q.push_back(e2);
    kind_q.push_back(len != 0 ? 1 : 2);
    if (len != 0 && (ptr & PTR_ALIGN_MASK) != 0) err_exp++;
    send_cmd(8);
  endtask : single

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: a hang counts as a mismatch and still reaches the verdict.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      finish_test;
    end
  end

  // Scoreboard: counts error pulses and compares each accepted group with the oldest expected.
  always @(posedge mclk) begin
    if (cmd_error === 1'b1) err_seen++;
    if (disp_valid === 1'b1 && disp_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("extra_group", 1, 0);
      end else begin
        e = exp_q.pop_front();
        f = kind_q.pop_front();
        check("group_xy", {disp.group_x, disp.group_y},
              {e.group_x, e.group_y});
        check("group_z_mask", {disp.group_z, disp.chan_mask},
              {e.group_z, e.chan_mask});
        check("simd_desc", {disp.simd, disp.desc_offset}, {e.simd, e.desc_offset});
        if (f == 0) check("thread_max", disp.thread_max, e.thread_max);
        if (f == 1) check("indirect", {disp.indirect_valid, disp.indirect_ptr},
                          {e.indirect_valid, e.indirect_ptr});
        if (f == 2) check("indirect_off", disp.indirect_valid, 1'b0);
      end
    end
  end

  // Main sequence; narrow widths keep their enables in the low mask bits.
  initial begin
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    for (int s = 0; s < 3; s++) begin
      for (int i = 0; i < 2; i++) begin
        stall_en = i[0];
        walk(2'(s), i[0], 1'b0, 1'b0);
        settle("walk");
      end
    end
    walk(SIMD32_CODE, 1'b0, 1'b1, 1'b0);
    settle("predicate_skip");
    walk(SIMD16_CODE, 1'b0, 1'b1, 1'b1);
    settle("predicate_run");
    single(17'h00000, 32'hffff_ffc5);
    single(17'h00040, 32'h0000_1240);
    single(17'h00040, 32'h0000_1241);
    single(17'h00100, 32'h2000_0000);
    settle("single_back_to_back");
    bad[0] = {CMD_TYPE_GFX, CMD_PIPE_MEDIA, CMD_OPCODE, SUBOP_WALK, 8'h00, 8'h08};
    bad[1] = {CMD_TYPE_GFX, CMD_PIPE_MEDIA, CMD_OPCODE, SUBOP_WALK, 8'h02, WALK_LENGTH_VALUE};
    bad[2] = {CMD_TYPE_GFX, CMD_PIPE_MEDIA, CMD_OPCODE, 8'h06, 8'h00, WALK_LENGTH_VALUE};
    for (int i = 0; i < 3; i++) begin
      dw[0] = bad[i];
      err_exp++;
      send_cmd(1);
    end
    settle("bad_header");
    finish_test;
  end
endmodule : compute_group_walker_decoder_tb_top

//--- testbench/dispatch_sink.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Execution-side receiver of thread groups; it takes groups promptly or with random stalls.
module dispatch_sink (
  // Clock and reset.
  input  wire logic MCLK,
  input  wire logic NRST,
  // Stall control from the bench.
  input  wire logic stall_en,
  // Handshake towards the walker.
  output logic      ready
);
  int seed = 62519;

  // Ready moves only at the falling edge, so the walker always samples a settled level.
  always @(negedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ready <= 1'b0;
    end else begin
      ready <= stall_en ? 1'($random(seed) & 1) : 1'b1;
    end
  end
endmodule : dispatch_sink
